// *** core/op_status_pkg.sv ***
// Constants shared by the sector operation completion status logic.
// Assumes a single 100 MHz clock and an active-low asynchronous reset.
`default_nettype none
package op_status_pkg;
    // Register offsets on the microcontroller port.
    localparam logic [7:0] OFS_OP_IRQ_FLAGS = 8'h22;
    localparam logic [7:0] OFS_MEDIA_FAULT = 8'h23;
    // Field positions in operation_interrupt_flags.
    localparam int IRQ_MEDIA_PEND = 7;
    localparam int IRQ_ECC_PEND = 6;
    localparam int IRQ_COUNT_ZERO = 1;
    localparam int IRQ_OP_DONE = 0;
    // Field positions in media_fault_flags.
    localparam int MED_PSEUDO_MARK = 7;
    localparam int MED_MARK_OUTSIDE = 6;
    localparam int MED_ID_ERROR = 5;
    localparam int MED_BLANK_ERR = 0;
    // Field positions in the ECC error status byte.
    localparam int ECC_HW_FAULT = 3;
    localparam int ECC_XFER_FAULT = 1;
    localparam int ECC_FW_FAULT = 0;
    // Field positions in the ID error cause.
    localparam int IDC_NOT_FOUND = 0;
    localparam int IDC_VOTE_FAIL = 1;
    localparam int IDC_ABOVE_TARGET = 2;
    // Revolutions allowed without a usable ID.
    localparam logic [1:0] REV_LIMIT = 2'h2;
    // Values after reset.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ID_TARGET = 16'h0000;
    // Operation modes from the sequencer.
    typedef enum logic [2:0] {
        MODE_WRITE = 3'b000,
        MODE_READ_ID = 3'b001,
        MODE_SEARCH_ID = 3'b010,
        MODE_BLANK_VERIFY = 3'b011,
        MODE_NONBLANK_VERIFY = 3'b100
    } op_mode_t;
    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ_ID = 3'b010,
        ST_SEARCH_ID = 3'b011,
        ST_VERIFY = 3'b100,
        ST_FINISH = 3'b101
    } op_state_t;
endpackage : op_status_pkg
`default_nettype wire

// *** core/sticky_flag.sv ***
// One sticky status bit: set by hardware, cleared by a write of one.
// Assumes set and clear are single-cycle pulses in the clk domain.
`default_nettype none
module sticky_flag (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Control.
    input wire logic set,
    input wire logic clr,
    // State.
    output logic q
);
    logic q_d;

    // A set in the cycle of a clear wins.
    always_comb begin
        q_d = set | (q & ~clr);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end
endmodule : sticky_flag
`default_nettype wire

// *** core/sector_op_completion_status.sv ***
// Completion and media error status for the disk sequencer operations.
// Assumes sequencer events are one-cycle pulses synchronous to clk.
//
// Behaviour
// - Write stop: raise completion, count holds sectors whose transfer never began.
// - Clean write ends with both pending indications clear and count zero.
// - ECC fault aborts a write, ECC pending set before completion.
// - Transfer fault bit 1: count already stepped for the failed sector.
// - ECC bit 3 marks internal hardware fault, bit 0 firmware fault.
// - Media fault aborts write, ECC pending clear, count frozen as is.
// - Read ID success loads target registers, completes without media error.
// - Read ID halts after two revolutions without good ID, sets ID error.
// - Search ID completes only on failure, runs until firmware halts it.
// - Search ID aborts after two revolutions without good ID, ID error.
// - Verify stop: count holds sectors not yet verified.
// - Clean verify completes with media pending clear and count zero.
// - Blank sector error: failing sector already counted off.
// - Media bits 7 to 1 abort verify with count frozen.
// - Writing one to a media status bit clears only that bit.
// - Writing one to media pending clears every media status bit.
// - Media bit 7 sets when a substitute sector mark is generated.
// - Media bit 6 sets on a sector mark outside an enabled window.
// - In ID search, bit 5 sets only on two revolutions without good ID.
// - Write and verify: bit 5 on target miss or failed ID vote.
// - Write and verify: bit 5 on good ID above target, cause recorded.
// - Interrupt bit 6 mirrors any ECC bit, writing one clears all.
// - Interrupt bit 0 sets when the operation completes or halts, except a halted ID search.
// - Media pending reads set whenever any media status bit is set.
`default_nettype none
module sector_op_completion_status
    import op_status_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Microcontroller register port.
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata_q,
    // Operation control.
    input wire logic op_start,
    input wire op_status_pkg::op_mode_t op_mode,
    input wire logic op_halt,
    input wire logic count_load,
    input wire logic [7:0] count_value,
    // Sequencer events.
    input wire logic sector_begin,
    input wire logic sector_end,
    input wire logic ecc_hw_fault,
    input wire logic ecc_xfer_fault,
    input wire logic ecc_fw_fault,
    input wire logic pseudo_mark,
    input wire logic mark_seen,
    input wire logic mark_window_en,
    input wire logic mark_window_open,
    input wire logic data_read_gate,
    input wire logic index_pulse,
    input wire logic id_good,
    input wire logic [15:0] id_value,
    input wire logic target_found,
    input wire logic id_vote_fail,
    input wire logic blank_err,
    // Status outputs.
    output logic [7:0] sector_count_q,
    output logic [15:0] id_target_q,
    output logic [7:0] ecc_status_q,
    output logic [2:0] id_err_cause_q,
    output logic op_active_q
);
    import op_status_pkg::*;

    op_state_t state_q, state_d;
    logic [1:0] rev_q;
    logic [7:0] med_bits, ecc_bits;
    logic wr_irq, wr_med, clr_all_med, clr_all_ecc;
    logic rev_timeout, id_above, id_err_set, media_abort, ecc_abort;
    logic done_set, done_q, search_mode;

    assign wr_irq = cpu_wr && (cpu_addr == OFS_OP_IRQ_FLAGS);
    assign wr_med = cpu_wr && (cpu_addr == OFS_MEDIA_FAULT);
    assign clr_all_med = wr_irq && cpu_wdata[IRQ_MEDIA_PEND];
    assign clr_all_ecc = wr_irq && cpu_wdata[IRQ_ECC_PEND];
    assign search_mode = (state_q == ST_SEARCH_ID);
    assign rev_timeout = (rev_q == REV_LIMIT);
    assign id_above = id_good && (id_value > id_target_q) && !search_mode;
    always_comb begin
        if (state_q == ST_SEARCH_ID || state_q == ST_READ_ID) begin
            id_err_set = rev_timeout;
        end else if (state_q == ST_WRITE || state_q == ST_VERIFY) begin
            id_err_set = rev_timeout || (target_found && id_vote_fail) || id_above;
        end else begin
            id_err_set = 1'b0;
        end
    end

    // Media status bits, each cleared alone or all together.
    sticky_flag u_med_pseudo (
        .clk(clk), .rst_b(rst_b),
        .set(pseudo_mark),
        .clr(clr_all_med || (wr_med && cpu_wdata[MED_PSEUDO_MARK])),
        .q(med_bits[MED_PSEUDO_MARK])
    );
    sticky_flag u_med_outside (
        .clk(clk), .rst_b(rst_b),
        .set(mark_seen && mark_window_en && !mark_window_open),
        .clr(clr_all_med || (wr_med && cpu_wdata[MED_MARK_OUTSIDE])),
        .q(med_bits[MED_MARK_OUTSIDE])
    );
    sticky_flag u_med_id (
        .clk(clk), .rst_b(rst_b),
        .set(id_err_set),
        .clr(clr_all_med || (wr_med && cpu_wdata[MED_ID_ERROR])),
        .q(med_bits[MED_ID_ERROR])
    );
    sticky_flag u_med_blank (
        .clk(clk), .rst_b(rst_b),
        .set(blank_err && state_q == ST_VERIFY),
        .clr(clr_all_med || (wr_med && cpu_wdata[MED_BLANK_ERR])),
        .q(med_bits[MED_BLANK_ERR])
    );
    assign med_bits[4:1] = 4'h0;

    // ECC status bits raised by aborted writes.
    sticky_flag u_ecc_hw (
        .clk(clk), .rst_b(rst_b),
        .set(ecc_hw_fault && state_q == ST_WRITE),
        .clr(clr_all_ecc), .q(ecc_bits[ECC_HW_FAULT])
    );
    sticky_flag u_ecc_xfer (
        .clk(clk), .rst_b(rst_b),
        .set(ecc_xfer_fault && state_q == ST_WRITE),
        .clr(clr_all_ecc), .q(ecc_bits[ECC_XFER_FAULT])
    );
    sticky_flag u_ecc_fw (
        .clk(clk), .rst_b(rst_b),
        .set(ecc_fw_fault && state_q == ST_WRITE),
        .clr(clr_all_ecc), .q(ecc_bits[ECC_FW_FAULT])
    );
    assign ecc_bits[7:4] = 4'h0;
    assign ecc_bits[2] = 1'b0;

    // Operation completion flag.
    assign done_set = (state_q == ST_FINISH) || (op_halt && state_q != ST_IDLE
        && state_q != ST_SEARCH_ID);
    sticky_flag u_done (
        .clk(clk), .rst_b(rst_b),
        .set(done_set),
        .clr(wr_irq && cpu_wdata[IRQ_OP_DONE]),
        .q(done_q)
    );

    assign ecc_abort = ecc_hw_fault || ecc_xfer_fault || ecc_fw_fault;
    assign media_abort = |med_bits[7:1];

    // Operation sequencer.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (op_start) begin
                    case (op_mode)
                        MODE_WRITE: state_d = ST_WRITE;
                        MODE_READ_ID: state_d = ST_READ_ID;
                        MODE_SEARCH_ID: state_d = ST_SEARCH_ID;
                        default: state_d = ST_VERIFY;
                    endcase
                end
            end
            ST_WRITE: begin
                if (op_halt) begin
                    state_d = ST_IDLE;
                end else if (ecc_abort || media_abort) begin
                    state_d = ST_FINISH;
                end else if (sector_end && sector_count_q == RST_BYTE) begin
                    state_d = ST_FINISH;
                end
            end
            ST_READ_ID: begin
                if (op_halt) begin
                    state_d = ST_IDLE;
                end else if (id_good || rev_timeout) begin
                    state_d = ST_FINISH;
                end
            end
            ST_SEARCH_ID: begin
                if (op_halt) begin
                    state_d = ST_IDLE;
                end else if (rev_timeout) begin
                    state_d = ST_FINISH;
                end
            end
            ST_VERIFY: begin
                if (op_halt) begin
                    state_d = ST_IDLE;
                end else if (blank_err || media_abort) begin
                    state_d = ST_FINISH;
                end else if (sector_end && sector_count_q == RST_BYTE) begin
                    state_d = ST_FINISH;
                end
            end
            ST_FINISH: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Sector count steps down as each sector's transfer or check begins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sector_count_q <= RST_BYTE;
        end else if (count_load && state_q == ST_IDLE) begin
            sector_count_q <= count_value;
        end else if (sector_begin && sector_count_q != RST_BYTE
                     && (state_q == ST_WRITE || state_q == ST_VERIFY)) begin
            sector_count_q <= sector_count_q - 8'h01;
        end
    end

    // Revolutions since the last usable ID or target sighting.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rev_q <= 2'h0;
        end else if (state_q == ST_IDLE || id_good
                     || (target_found && !id_vote_fail)) begin
            rev_q <= 2'h0;
        end else if (index_pulse && !rev_timeout) begin
            rev_q <= rev_q + 2'h1;
        end
    end

    // ID target capture on any error-free ID in the ID modes.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            id_target_q <= RST_ID_TARGET;
        end else if (id_good && (state_q == ST_READ_ID || state_q == ST_SEARCH_ID)) begin
            id_target_q <= id_value;
        end
    end

    // ID error cause, cleared with the ID error bit.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            id_err_cause_q <= 3'h0;
        end else if (id_err_set) begin
            id_err_cause_q <= {id_above, target_found && id_vote_fail, rev_timeout};
        end else if (clr_all_med || (wr_med && cpu_wdata[MED_ID_ERROR])) begin
            id_err_cause_q <= 3'h0;
        end
    end

    // Register read data and status mirrors.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata_q <= RST_BYTE;
        end else if (cpu_rd && cpu_addr == OFS_OP_IRQ_FLAGS) begin
            cpu_rdata_q <= {|med_bits, |ecc_bits, 4'h0,
                            sector_count_q == RST_BYTE, done_q};
        end else if (cpu_rd && cpu_addr == OFS_MEDIA_FAULT) begin
            cpu_rdata_q <= med_bits;
        end else if (cpu_rd) begin
            cpu_rdata_q <= RST_BYTE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ecc_status_q <= RST_BYTE;
            op_active_q <= 1'b0;
        end else begin
            ecc_status_q <= ecc_bits;
            op_active_q <= (state_d != ST_IDLE) && (state_d != ST_FINISH);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_write_ecc_fault;
        state_q == ST_WRITE && !op_halt && ecc_abort;
    endsequence
    sequence s_finish_then_done;
        state_q == ST_FINISH ##1 done_q;
    endsequence

    a_ecc_before_done: assert property (s_write_ecc_fault |=> (|ecc_bits) && !done_q
        ##0 s_finish_then_done)
        else $error("ECC fault did not precede completion");
    a_clean_write_end: assert property (state_q == ST_WRITE && !op_halt && !ecc_abort
        && !media_abort && sector_end && sector_count_q == 8'h00 && ecc_bits == 8'h00
        && med_bits == 8'h00 |=> state_q == ST_FINISH && sector_count_q == 8'h00)
        else $error("Clean write did not finish at zero");
    a_search_silent: assert property (state_q == ST_SEARCH_ID && !rev_timeout
        |=> state_q != ST_FINISH)
        else $error("Search completed without failing");
    a_search_timeout: assert property (state_q == ST_SEARCH_ID && !op_halt && rev_timeout
        |=> med_bits[MED_ID_ERROR] ##1 done_q)
        else $error("Search timeout missed ID error");
    a_readid_load: assert property (state_q == ST_READ_ID && id_good && !op_halt
        |=> id_target_q == $past(id_value) ##1 done_q)
        else $error("Read ID did not load target");
    a_media_clear_all: assert property (wr_irq && cpu_wdata[7] && !pseudo_mark
        && !id_err_set |=> !med_bits[MED_PSEUDO_MARK] && !med_bits[MED_ID_ERROR])
        else $error("Media pending write did not clear");
    a_outside_mark: assert property (mark_seen && mark_window_en && !mark_window_open
        |=> med_bits[MED_MARK_OUTSIDE])
        else $error("Outside mark not flagged");
    a_count_step: assert property ((state_q == ST_WRITE || state_q == ST_VERIFY)
        && sector_begin && sector_count_q != 8'h00 && !count_load
        |=> sector_count_q == $past(sector_count_q) - 8'h01)
        else $error("Sector count did not step");
    a_ecc_pend_read: assert property (cpu_rd && cpu_addr == OFS_OP_IRQ_FLAGS
        |=> cpu_rdata_q[6] == |$past(ecc_bits) && cpu_rdata_q[7] == |$past(med_bits))
        else $error("Pending bits misreport");
endmodule : sector_op_completion_status
`default_nettype wire

// *** dv/fw_model.sv ***
// Firmware model: byte reads and writes on the microcontroller register port.
// Assumes the design clock is shared; strobes are one-cycle pulses.
`default_nettype none
module fw_model (
    // Clock.
    input wire logic clk,
    // Register port.
    output logic [7:0] cpu_addr,
    output logic cpu_wr,
    output logic cpu_rd,
    output logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cpu_addr = 8'h00;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
    end
    // The data lines show the inverse once a write is over, so a late sample is caught.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge clk);
        cpu_wr <= 1'b0;
        cpu_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk);
        cpu_rd <= 1'b0;
        #1;
        d = cpu_rdata_q;
    endtask : rd
    // Writing one to media pending clears every media status bit.
    task automatic clear_all();
        wr(8'h22, 8'h80);
    endtask : clear_all
endmodule : fw_model
`default_nettype wire

// *** dv/sector_op_completion_status_tb.sv ***
// Self-checking bench for the operation completion and media error status block.
// Assumes the firmware model drives the register port; events are bench pulses.
`default_nettype none
module sector_op_completion_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import op_status_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata_q, count_value, sector_count_q, ecc_status_q;
    logic cpu_wr, cpu_rd, op_active_q;
    logic [13:0] ev = 14'h0000;
    op_mode_t op_mode = MODE_WRITE;
    logic win_en = 1'b0;
    logic win_open = 1'b0;
    logic read_gate = 1'b0;
    logic vote_fail = 1'b0;
    logic [15:0] id_value = 16'h0000;
    logic [15:0] id_target_q;
    logic [2:0] id_err_cause_q;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    fw_model fw_model_i (.clk(clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q));
    sector_op_completion_status sector_op_completion_status_i (.clk(clk), .rst_b(rst_b),
        .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
        .cpu_rdata_q(cpu_rdata_q), .op_start(ev[11]), .op_mode(op_mode), .op_halt(ev[12]),
        .count_load(ev[13]), .count_value(count_value), .sector_begin(ev[0]),
        .sector_end(ev[1]), .ecc_hw_fault(ev[2]), .ecc_xfer_fault(ev[3]),
        .ecc_fw_fault(ev[4]), .pseudo_mark(ev[5]), .mark_seen(ev[6]),
        .mark_window_en(win_en), .mark_window_open(win_open), .data_read_gate(read_gate),
        .index_pulse(ev[7]), .id_good(ev[8]), .id_value(id_value), .target_found(ev[9]),
        .id_vote_fail(vote_fail), .blank_err(ev[10]), .sector_count_q(sector_count_q),
        .id_target_q(id_target_q), .ecc_status_q(ecc_status_q),
        .id_err_cause_q(id_err_cause_q), .op_active_q(op_active_q));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("Mismatches %0d of %0d comparisons", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
    endtask : pulse
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        fw_model_i.rd(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask : rd_chk
    task automatic start_op(input op_mode_t m, input logic [7:0] n);
        count_value <= n;
        pulse(13);
        op_mode <= m;
        pulse(11);
    endtask : start_op
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle
    task automatic write_paths();
        start_op(MODE_WRITE, 8'h02);
        repeat (2) begin
            pulse(0);
            pulse(1);
        end
        settle();
        check(sector_count_q, 16'h0000);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h03);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h01);
        for (int k = 0; k < 3; k++) begin
            start_op(MODE_WRITE, 8'h03);
            pulse(0);
            pulse(2 + k);
            settle();
            check(ecc_status_q, 16'h0001 << (k == 0 ? 3 : 2 - k));
            check(sector_count_q, 16'h0002);
            rd_chk(OFS_OP_IRQ_FLAGS, 8'h41);
            fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h41);
            settle();
            check(ecc_status_q, 16'h0000);
        end
        start_op(MODE_WRITE, 8'h02);
        pulse(0);
        pulse(5);
        settle();
        check(sector_count_q, 16'h0001);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h81);
        rd_chk(OFS_MEDIA_FAULT, 8'h80);
        fw_model_i.wr(OFS_MEDIA_FAULT, 8'h80);
        rd_chk(OFS_MEDIA_FAULT, 8'h00);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h01);
    endtask : write_paths
    task automatic id_paths();
        start_op(MODE_READ_ID, 8'h00);
        id_value <= 16'hA5C3;
        pulse(8);
        settle();
        check(id_target_q, 16'hA5C3);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h03);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h01);
        start_op(MODE_READ_ID, 8'h00);
        pulse(7);
        pulse(7);
        settle();
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h83);
        rd_chk(OFS_MEDIA_FAULT, 8'h20);
        check(id_err_cause_q[0], 16'h0001);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h81);
        start_op(MODE_SEARCH_ID, 8'h00);
        repeat (3) begin
            pulse(7);
            pulse(8);
        end
        check(op_active_q, 16'h0001);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h02);
        pulse(7);
        pulse(7);
        settle();
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h83);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h81);
        start_op(MODE_SEARCH_ID, 8'h00);
        pulse(12);
        settle();
        check(op_active_q, 16'h0000);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h02);
    endtask : id_paths
    task automatic verify_paths();
        start_op(MODE_BLANK_VERIFY, 8'h03);
        pulse(0);
        pulse(1);
        pulse(0);
        pulse(10);
        settle();
        check(sector_count_q, 16'h0001);
        rd_chk(OFS_MEDIA_FAULT, 8'h01);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h81);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h81);
        start_op(MODE_NONBLANK_VERIFY, 8'h01);
        pulse(0);
        pulse(1);
        settle();
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h03);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h01);
        win_en <= 1'b1;
        read_gate <= 1'b1;
        start_op(MODE_BLANK_VERIFY, 8'h02);
        pulse(0);
        pulse(6);
        settle();
        check(sector_count_q, 16'h0001);
        rd_chk(OFS_MEDIA_FAULT, 8'h40);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h81);
        pulse(5);
        rd_chk(OFS_MEDIA_FAULT, 8'hC0);
        fw_model_i.wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        fw_model_i.clear_all();
        rd_chk(OFS_MEDIA_FAULT, 8'h00);
    endtask : verify_paths
    task automatic id_err_paths();
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h81);
        vote_fail <= 1'b1;
        start_op(MODE_BLANK_VERIFY, 8'h02);
        pulse(9);
        settle();
        rd_chk(OFS_MEDIA_FAULT, 8'h20);
        check(id_err_cause_q, 16'h0001 << IDC_VOTE_FAIL);
        check(sector_count_q, 16'h0002);
        vote_fail <= 1'b0;
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h81);
        start_op(MODE_WRITE, 8'h01);
        id_value <= 16'hFFFF;
        pulse(8);
        settle();
        check(id_err_cause_q, 16'h0001 << IDC_ABOVE_TARGET);
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h81);
        fw_model_i.wr(OFS_MEDIA_FAULT, 8'h20);
        rd_chk(OFS_MEDIA_FAULT, 8'h00);
        check(id_err_cause_q, 16'h0000);
        fw_model_i.wr(OFS_OP_IRQ_FLAGS, 8'h01);
    endtask : id_err_paths
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        count_value = 8'h00;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(OFS_OP_IRQ_FLAGS, 8'h02);
        rd_chk(OFS_MEDIA_FAULT, 8'h00);
        write_paths();
        id_paths();
        verify_paths();
        id_err_paths();
        complete_run();
    end
endmodule : sector_op_completion_status_tb
`default_nettype wire
